// ---- core/manchester_prog_access_lock.sv ----
// Programming serial interface with power-up default lock and permanent lock
`timescale 1ns/1ps
module manchester_prog_access_lock #(
	parameter int P_ACC_WINDOW_CYC = mpl_pkg::ACC_WINDOW_CYC,
	parameter logic [mpl_pkg::DATA_W-1:0] P_ACCESS_CODE = mpl_pkg::ACCESS_CODE_DEF
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_vcc_man,
	input wire logic i_prog_strobe,
	input wire logic i_perm_lock_nv,
	input wire logic [mpl_pkg::DATA_W-1:0] i_mem_rdata,
	output logic [mpl_pkg::ADDR_W-1:0] o_mem_addr,
	output logic [mpl_pkg::DATA_W-1:0] o_mem_wdata,
	output logic o_mem_we,
	output logic o_out_o,
	output logic o_out_oe,
	output logic o_normal_en,
	output logic o_ee_gate,
	output logic o_unlocked
);
	import mpl_pkg::*;

	typedef enum logic [1:0] {T_IDLE, T_LOW, T_SEND, T_REL} tx_state_t;

	function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
		logic fb;
		fb = c[2] ^ b;
		crc_step = {c[1], c[0] ^ fb, fb};
	endfunction

	function automatic logic [CRC_W-1:0] crc_word(input logic [DATA_W-1:0] d);
		logic [CRC_W-1:0] c;
		c = CRC_INIT;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			c = crc_step(c, d[i]);
		end
		crc_word = c;
	endfunction

	logic rx_bit_vld, rx_bit, rx_end;
	logic [HALF_W-1:0] rx_half;

	manchester_rx u_rx (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_line(i_vcc_man),
		.o_bit_vld(rx_bit_vld),
		.o_bit(rx_bit),
		.o_frame_end(rx_end),
		.o_half(rx_half)
	);

	logic [WR_BITS-1:0] sh_ff;
	logic [NB_W-1:0] nbits_ff;
	logic [CRC_W-1:0] crc_ff;
	logic [WIN_W-1:0] win_ff;
	logic perm_ff, cap_ff, pend_ff;
	logic st1_ff, st2_ff, st3_ff, st_lvl_ff, strobes_ff;
	tx_state_t tx_ff;
	logic [TCNT_W-1:0] tcnt_ff;
	logic [HALF_W-1:0] hcnt_ff;
	logic phase_ff;
	logic [ACK_BITS-1:0] ack_ff;
	logic [NB_W-1:0] abits_ff;

	// Frame decode, fields MSB first
	wire logic crc_ok = crc_ff == 3'h0;
	wire logic is_rd_frame = nbits_ff == NB_W'(RD_BITS);
	wire logic is_wr_frame = nbits_ff == NB_W'(WR_BITS);
	wire logic [CMD_W-1:0] rd_cmd = sh_ff[RD_BITS-1 -: CMD_W];
	wire logic [ADDR_W-1:0] rd_addr = sh_ff[RD_BITS-CMD_W-1 -: ADDR_W];
	wire logic [CMD_W-1:0] wr_cmd = sh_ff[WR_BITS-1 -: CMD_W];
	wire logic [ADDR_W-1:0] wr_addr = sh_ff[WR_BITS-CMD_W-1 -: ADDR_W];
	wire logic [DATA_W-1:0] wr_data = sh_ff[CRC_W +: DATA_W];
	wire logic frame_ok = rx_end && crc_ok && tx_ff == T_IDLE;
	wire logic win_open = win_ff < WIN_W'(P_ACC_WINDOW_CYC);
	wire logic do_read = frame_ok && is_rd_frame && rd_cmd == CMD_READ && o_unlocked;
	wire logic do_write = frame_ok && is_wr_frame && wr_cmd == CMD_WRITE && o_unlocked;
	wire logic code_ok = wr_cmd == CMD_ACCESS && wr_addr == ACCESS_ADDR && wr_data == P_ACCESS_CODE;
	// Late or wrong codes are ignored; the stored lock bit wins over any code
	wire logic do_unlock = frame_ok && is_wr_frame && code_ok && win_open && cap_ff && !perm_ff;
	wire logic nxt_st_lvl = (st2_ff == st3_ff) ? st3_ff : st_lvl_ff;
	wire logic strobe_rise = nxt_st_lvl && !st_lvl_ff;
	wire logic strobe_fall = !nxt_st_lvl && st_lvl_ff;
	wire logic half_done = hcnt_ff == rx_half;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st1_ff <= 1'b0;
			st2_ff <= 1'b0;
			st3_ff <= 1'b0;
		end else begin
			st1_ff <= i_prog_strobe;
			st2_ff <= st1_ff;
			st3_ff <= st2_ff;
		end
	end

	// Frame assembly; CRC over all bits after sync leaves zero on a good frame
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || rx_end) begin
			sh_ff <= '0;
			nbits_ff <= '0;
			crc_ff <= CRC_INIT;
		end else if (rx_bit_vld) begin
			sh_ff <= {sh_ff[WR_BITS-2:0], rx_bit};
			nbits_ff <= (nbits_ff == 6'h3f) ? nbits_ff : nbits_ff + 6'h1;
			crc_ff <= crc_step(crc_ff, rx_bit);
		end
	end

	// Lock state lives only in this session; reset is the power-on reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			win_ff <= '0;
			cap_ff <= 1'b0;
			perm_ff <= 1'b0;
			o_unlocked <= 1'b0;
		end else begin
			if (win_open) begin
				win_ff <= win_ff + 22'h1;
			end
			if (!cap_ff) begin
				// Lock bit written now is only seen at the next power-up
				cap_ff <= 1'b1;
				perm_ff <= i_perm_lock_nv;
			end
			if (do_unlock) begin
				o_unlocked <= 1'b1;
			end
		end
	end

	// Standard write waits for strobes on this device's own output pin
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_lvl_ff <= 1'b0;
			pend_ff <= 1'b0;
			strobes_ff <= 1'b0;
			o_mem_addr <= '0;
			o_mem_wdata <= '0;
			o_mem_we <= 1'b0;
			o_ee_gate <= 1'b0;
		end else begin
			st_lvl_ff <= nxt_st_lvl;
			o_mem_we <= 1'b0;
			o_ee_gate <= pend_ff && nxt_st_lvl;
			if (do_write) begin
				pend_ff <= 1'b1;
				strobes_ff <= 1'b0;
				o_mem_addr <= wr_addr;
				o_mem_wdata <= wr_data;
			end else if (do_read) begin
				pend_ff <= 1'b0;
				o_mem_addr <= rd_addr;
			end else if (pend_ff && strobe_rise && !strobes_ff) begin
				o_mem_we <= 1'b1;
			end else if (pend_ff && strobe_fall) begin
				strobes_ff <= 1'b1;
				pend_ff <= !strobes_ff;
			end
		end
	end

	// Acknowledge only follows a read, timed by the measured half bit
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			tx_ff <= T_IDLE;
			tcnt_ff <= '0;
			hcnt_ff <= '0;
			phase_ff <= 1'b0;
			ack_ff <= '0;
			abits_ff <= '0;
			o_out_o <= 1'b0;
			o_out_oe <= 1'b0;
			o_normal_en <= 1'b1;
		end else begin
			tcnt_ff <= tcnt_ff + 12'h1;
			unique case (tx_ff)
				T_IDLE: begin
					tcnt_ff <= '0;
					if (do_read) begin
						tx_ff <= T_LOW;
						o_normal_en <= 1'b0;
						o_out_oe <= 1'b1;
						o_out_o <= 1'b0;
					end
				end
				T_LOW: begin
					if (tcnt_ff == TCNT_W'(READ_DELAY_CYC - 1)) begin
						tx_ff <= T_SEND;
						ack_ff <= {i_mem_rdata, crc_word(i_mem_rdata)};
						abits_ff <= '0;
						hcnt_ff <= '0;
						phase_ff <= 1'b0;
						o_out_o <= i_mem_rdata[DATA_W-1];
					end
				end
				T_SEND: begin
					hcnt_ff <= hcnt_ff + 13'h1;
					if (half_done) begin
						hcnt_ff <= '0;
						phase_ff <= !phase_ff;
						if (!phase_ff) begin
							o_out_o <= !ack_ff[ACK_BITS-1];
						end else if (abits_ff == NB_W'(ACK_BITS - 1)) begin
							tx_ff <= T_REL;
							tcnt_ff <= '0;
							o_out_oe <= 1'b0;
						end else begin
							abits_ff <= abits_ff + 6'h1;
							ack_ff <= {ack_ff[ACK_BITS-2:0], 1'b0};
							o_out_o <= ack_ff[ACK_BITS-2];
						end
					end
				end
				T_REL: begin
					if (tcnt_ff == TCNT_W'(ROUT_EN_CYC - 1)) begin
						tx_ff <= T_IDLE;
						o_normal_en <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule // manchester_prog_access_lock

// ---- core/mpl_pkg.sv ----
// Constants shared by the programming interface and its Manchester receiver
package mpl_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	// Access window after power-up
	localparam int ACC_WINDOW_MS = 70;
	localparam int ACC_WINDOW_CYC = ACC_WINDOW_MS * (CLK_HZ / 1000);
	localparam int WIN_W = 22;
	// Read command end to acknowledge start, output held low meanwhile
	localparam int READ_DELAY_US = 50;
	localparam int READ_DELAY_CYC = READ_DELAY_US * CLK_PER_US;
	// Acknowledge end to normal output again
	localparam int ROUT_EN_US = 45;
	localparam int ROUT_EN_CYC = ROUT_EN_US * CLK_PER_US;
	localparam int TCNT_W = 12;
	// Bit timing: 4 kbps half bit is 125 us, 5000 cycles
	localparam int HALF_W = 13;
	localparam int RXCNT_W = 15;
	localparam logic [RXCNT_W-1:0] HALF_LIMIT = 15'h1fff;
	// Frame layout
	localparam int CMD_W = 2;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 30;
	localparam int CRC_W = 3;
	localparam int WR_BITS = CMD_W + ADDR_W + DATA_W + CRC_W;
	localparam int RD_BITS = CMD_W + ADDR_W + CRC_W;
	localparam int ACK_BITS = DATA_W + CRC_W;
	localparam int NB_W = 6;
	localparam logic [CRC_W-1:0] CRC_INIT = 3'h7;
	localparam logic [CMD_W-1:0] CMD_WRITE = 2'h0;
	localparam logic [CMD_W-1:0] CMD_READ = 2'h1;
	localparam logic [CMD_W-1:0] CMD_ACCESS = 2'h2;
	localparam logic [ADDR_W-1:0] ACCESS_ADDR = 6'h24;
	// Arbitrary neutral customer access code
	localparam logic [DATA_W-1:0] ACCESS_CODE_DEF = 30'h15a5a5a5;
endpackage

// ---- core/manchester_rx.sv ----
// Manchester receiver that measures the half-bit period from the frame's sync bit
`timescale 1ns/1ps
module manchester_rx (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_line,
	output logic o_bit_vld,
	output logic o_bit,
	output logic o_frame_end,
	output logic [mpl_pkg::HALF_W-1:0] o_half
);
	import mpl_pkg::*;

	typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_RUN} rx_state_t;

	rx_state_t state_ff;
	logic s1_ff, s2_ff, s3_ff, lvl_ff;
	logic [RXCNT_W-1:0] cnt_ff;
	wire logic nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
	wire logic edge_seen = nxt_lvl != lvl_ff;
	wire logic [RXCNT_W-1:0] half_x = {2'h0, o_half};
	// Mid-bit edges arrive near two half periods, boundary edges near one
	wire logic mid_edge = cnt_ff >= half_x + (half_x >> 1);
	wire logic timeout = cnt_ff > half_x + half_x + half_x;

	// Idle level in reset, so no false edge follows a short reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else begin
			s1_ff <= i_line;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			lvl_ff <= 1'b1;
			state_ff <= RX_IDLE;
			cnt_ff <= '0;
			o_half <= '0;
			o_bit_vld <= 1'b0;
			o_bit <= 1'b0;
			o_frame_end <= 1'b0;
		end else begin
			lvl_ff <= nxt_lvl;
			o_bit_vld <= 1'b0;
			o_frame_end <= 1'b0;
			cnt_ff <= cnt_ff + 15'h1;
			unique case (state_ff)
				RX_IDLE: begin
					cnt_ff <= '0;
					if (edge_seen && !nxt_lvl) begin
						state_ff <= RX_MEAS;
					end
				end
				RX_MEAS: begin
					if (edge_seen) begin
						o_half <= cnt_ff[HALF_W-1:0];
						cnt_ff <= '0;
						state_ff <= RX_RUN;
					end else if (cnt_ff == HALF_LIMIT) begin
						state_ff <= RX_IDLE;
					end
				end
				RX_RUN: begin
					if (timeout) begin
						o_frame_end <= 1'b1;
						state_ff <= RX_IDLE;
					end else if (edge_seen && mid_edge) begin
						o_bit_vld <= 1'b1;
						o_bit <= !nxt_lvl;
						cnt_ff <= '0;
					end
				end
			endcase
		end
	end
endmodule // manchester_rx

// ---- test/mpl_ctrl.sv ----
// Programming controller model: frames on the supply line, strobes on the output
`timescale 1ns/1ps
module mpl_ctrl (
	input wire logic i_clock,
	output logic o_vcc,
	output logic o_strobe
);
	// 100 kbps, the fastest rate, keeps the run short
	localparam int HALF = 200;
	initial begin
		o_vcc = 1'b1;
		o_strobe = 1'b0;
	end
	function automatic logic [2:0] crc(input logic [40:0] b, input int n);
		logic [2:0] c;
		logic fb;
		c = 3'h7;
		for (int i = n - 1; i >= 0; i--) begin
			fb = c[2] ^ b[i];
			c = {c[1], c[0] ^ fb, fb};
		end
		return c;
	endfunction
	task automatic half(input logic v);
		o_vcc <= v;
		repeat (HALF) @(posedge i_clock);
	endtask
	// Bad flips the crc low bit
	task automatic frame(input logic [40:0] b, input int n, input logic bad);
		logic [43:0] f;
		f = {b, 3'h0} | {41'h0, crc(b, n) ^ {2'h0, bad}};
		@(posedge i_clock);
		half(1'b0);
		half(1'b1);
		for (int i = n + 2; i >= 0; i--) begin
			half(f[i]);
			half(!f[i]);
		end
		o_vcc <= 1'b1;
	endtask
	task automatic strobes();
		repeat (2) begin
			o_strobe <= 1'b1;
			repeat (800) @(posedge i_clock);
			o_strobe <= 1'b0;
			repeat (800) @(posedge i_clock);
		end
	endtask
endmodule // mpl_ctrl

// ---- test/mpl_chk.sv ----
// Port assertions for the programming access lock
`timescale 1ns/1ps
module mpl_chk (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_vcc_man,
	input wire logic i_prog_strobe,
	input wire logic i_perm_lock_nv,
	input wire logic o_mem_we,
	input wire logic o_out_o,
	input wire logic o_out_oe,
	input wire logic o_normal_en,
	input wire logic o_ee_gate,
	input wire logic o_unlocked
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	sequence out_low8;
		!o_out_o [*8];
	endsequence
	sequence normal_off8;
		!o_normal_en [*8];
	endsequence
	locked_no_ack_a: assert property (!o_unlocked |-> !o_out_oe)
		else $error("ack while locked");
	ack_low_lead_a: assert property ($rose(o_out_oe) |-> out_low8)
		else $error("ack not led by low level");
	resume_late_a: assert property ($fell(o_out_oe) |-> normal_off8)
		else $error("normal output resumed too early");
	ack_on_idle_a: assert property ($rose(o_out_oe) |-> $past(i_vcc_man) && $past(i_vcc_man, 8))
		else $error("ack started during a frame");
	commit_strobe_a: assert property (o_mem_we |-> $past(i_prog_strobe, 2) && o_unlocked)
		else $error("write without strobe or unlock");
	we_single_a: assert property (o_mem_we |=> !o_mem_we)
		else $error("write pulse too long");
	gate_strobe_a: assert property (o_ee_gate |-> $past(i_prog_strobe, 2) || $past(i_prog_strobe, 5))
		else $error("gate high without strobe");
	// Lock bit as it stood at power-up; later writes only count next session
	logic cap_done_ff, perm_up_ff;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cap_done_ff <= 1'b0;
			perm_up_ff <= 1'b0;
		end else if (!cap_done_ff) begin
			cap_done_ff <= 1'b1;
			perm_up_ff <= i_perm_lock_nv;
		end
	end
	perm_blocks_a: assert property ($rose(o_unlocked) |-> !perm_up_ff)
		else $error("unlock despite permanent lock");
endmodule // mpl_chk
bind manchester_prog_access_lock mpl_chk chk (.i_clock, .i_rst_n, .i_vcc_man, .i_prog_strobe,
	.i_perm_lock_nv, .o_mem_we, .o_out_o, .o_out_oe, .o_normal_en, .o_ee_gate, .o_unlocked);

// ---- test/tb_top.sv ----
// Self-checking bench for the programming access lock
`timescale 1ns/1ps
module tb_top;
	import mpl_pkg::*;
	typedef struct {logic [1:0] c; logic [5:0] a; logic [29:0] d; logic bad, ack, unl;} row_t;
	logic i_clock, i_rst_n, i_vcc_man, i_prog_strobe, i_perm_lock_nv;
	logic o_mem_we, o_out_o, o_out_oe, o_normal_en, o_ee_gate, o_unlocked;
	logic [ADDR_W-1:0] o_mem_addr;
	logic [DATA_W-1:0] o_mem_wdata, i_mem_rdata;
	int failures = 0;
	int check_count = 0;
	int we_cnt = 0;
	int gate_cnt = 0;
	row_t rows[4];
	assign i_mem_rdata = {o_mem_addr, 24'hc3a5e1};
	mpl_ctrl ctl (.i_clock, .o_vcc(i_vcc_man), .o_strobe(i_prog_strobe));
	manchester_prog_access_lock #(.P_ACC_WINDOW_CYC(40000)) dut (.i_clock, .i_rst_n, .i_vcc_man,
		.i_prog_strobe, .i_perm_lock_nv, .i_mem_rdata, .o_mem_addr, .o_mem_wdata, .o_mem_we,
		.o_out_o, .o_out_oe, .o_normal_en, .o_ee_gate, .o_unlocked);
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		we_cnt <= we_cnt + o_mem_we;
		gate_cnt <= gate_cnt + o_ee_gate;
	end
	task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic do_reset();
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		@(negedge i_clock);
	endtask
	task automatic wait_hi(input bit use_norm, input int lim, output logic got);
		got = 1'b0;
		for (int k = 0; k < lim && !got; k++) begin
			@(negedge i_clock);
			got = use_norm ? (o_normal_en === 1'b1) : (o_out_oe === 1'b1);
		end
	endtask
	// Resyncs on every mid-bit edge, so rate drift cannot pile up
	task automatic read_ack(output logic [32:0] v);
		repeat (READ_DELAY_CYC + 100) @(negedge i_clock);
		for (int i = 32; i >= 0; i--) begin
			v[i] = o_out_o;
			for (int k = 0; k < 400 && o_out_o === v[i]; k++) @(negedge i_clock);
			if (o_out_o === v[i]) begin
				check("ack edge", 1'b0, 1'b1);
				final_report();
			end
			repeat (300) @(negedge i_clock);
		end
	endtask
	task automatic run_row(input row_t r);
		logic got;
		logic [32:0] v;
		logic [29:0] d;
		if (r.c == CMD_READ) ctl.frame({33'h0, r.c, r.a}, 8, r.bad);
		else ctl.frame({3'h0, r.c, r.a, r.d}, 38, r.bad);
		wait_hi(1'b0, 800, got);
		check("ack", got, r.ack);
		if (r.ack) begin
			if (!got) final_report();
			read_ack(v);
			d = {r.a, 24'hc3a5e1};
			check("ack data", v, {d, ctl.crc({11'h0, d}, 30)});
			wait_hi(1'b1, 3000, got);
			check("normal", got, 1'b1);
			if (!got) final_report();
		end
		check("unlocked", o_unlocked, r.unl);
		$display("row done");
	endtask
	initial begin
		int w0;
		int g0;
		i_perm_lock_nv <= 1'b0;
		rows[0] = '{CMD_READ, 6'h05, 30'h0, 1'b0, 1'b0, 1'b0};
		rows[1] = '{CMD_ACCESS, ACCESS_ADDR, ACCESS_CODE_DEF, 1'b0, 1'b0, 1'b1};
		rows[2] = '{CMD_READ, 6'h13, 30'h0, 1'b0, 1'b1, 1'b1};
		rows[3] = '{CMD_READ, 6'h13, 30'h0, 1'b1, 1'b0, 1'b1};
		do_reset();
		check("reset lock", o_unlocked, 1'b0);
		check("reset normal", o_normal_en, 1'b1);
		foreach (rows[i]) run_row(rows[i]);
		// Lock bit stored mid-session must not block this session
		@(posedge i_clock);
		i_perm_lock_nv <= 1'b1;
		w0 = we_cnt;
		g0 = gate_cnt;
		ctl.frame({3'h0, CMD_WRITE, 6'h0a, 30'h2bcd1234}, 38, 1'b0);
		repeat (1600) @(posedge i_clock);
		ctl.strobes();
		@(negedge i_clock);
		check("we count", we_cnt - w0, 1);
		check("addr", o_mem_addr, 6'h0a);
		check("wdata", o_mem_wdata, 30'h2bcd1234);
		check("gate", gate_cnt - g0 inside {[1590:1610]}, 1'b1);
		check("still open", o_unlocked, 1'b1);
		$display("write done");
		@(posedge i_clock);
		do_reset();
		check("relock", o_unlocked, 1'b0);
		ctl.frame({3'h0, CMD_ACCESS, ACCESS_ADDR, ACCESS_CODE_DEF}, 38, 1'b0);
		repeat (800) @(negedge i_clock);
		check("perm lock", o_unlocked, 1'b0);
		$display("perm lock done");
		final_report();
	end
endmodule // tb_top
